// ==== design/digital_io_port.sv ====
// two eight-pin i/o ports with edge interrupts behind an axi4-lite slave
`timescale 1ns/10ps
module digital_io_port
    import gpio_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic [2:0] s_axi_awprot, // write protection, unused
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic [2:0] s_axi_arprot, // read protection, unused
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [NPORT-1:0][NPIN-1:0] pin_level, // pad input levels
    output logic [NPORT-1:0][NPIN-1:0] pin_drive, // pad output value
    output logic [NPORT-1:0][NPIN-1:0] pin_drive_oe, // pad driver on
    output logic [NPORT-1:0][NPIN-1:0] pull_en, // weak pull on
    output logic [NPORT-1:0][NPIN-1:0] pull_up, // 1 pull up, 0 down
    input wire logic [NPORT-1:0][NPIN-1:0] prim_periph_data, // primary out
    input wire logic [NPORT-1:0][NPIN-1:0] sec_periph_data, // secondary out
    output logic [NPORT-1:0][NPIN-1:0] periph_input, // latched to periph
    output logic osc_timer_in, // ored pin oscillator signal
    output logic [NPORT-1:0] port_irq // one request per port
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [NPORT-1:0][NPIN-1:0] out_r;
    logic [NPORT-1:0][NPIN-1:0] dir_r;
    logic [NPORT-1:0][NPIN-1:0] ren_r;
    logic [NPORT-1:0][NPIN-1:0] sel_r;
    logic [NPORT-1:0][NPIN-1:0] sel2_r;
    logic [NPORT-1:0][NPIN-1:0] ies_r;
    logic [NPORT-1:0][NPIN-1:0] ie_r;
    logic [NPORT-1:0][NPIN-1:0] osc_r;
    logic gie_r;
    logic [NPORT-1:0][NPIN-1:0] level_sync;
    logic [NPORT-1:0][NPIN-1:0] flags;
    logic [NPORT-1:0] flag_wr;

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    logic awready_r;
    logic wready_r;
    logic aw_have_r;
    logic w_have_r;
    logic [ADDR_W-1:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_go;
    logic wr_ok;
    logic wr_lane0;
    logic wr_global;
    logic [NPORT-1:0] wr_port;
    logic [5:0] wr_off;

    assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_lane0 = wr_go & wstrb_r[0];
    assign wr_global = waddr_r[GLOBAL_SEL_BIT];
    assign wr_off = waddr_r[5:0];

    always_comb begin
        wr_ok = 1'b0;
        if (waddr_r[1:0] == 2'b00) begin
            if (wr_global) begin
                wr_ok = (waddr_r[6:0] == OFF_GLOBAL_CTRL);
            end else begin
                wr_ok = (wr_off <= OFF_OSC_ENABLE);
            end
        end
    end

    always_comb begin
        wr_port = '0;
        if (wr_lane0 && wr_ok && !wr_global) begin
            wr_port[waddr_r[PORT_SEL_BIT]] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            aw_have_r <= 1'b0;
            waddr_r <= '0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_have_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            w_have_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie_r <= RST_GIE;
        end else if (wr_lane0 && wr_ok && wr_global) begin
            gie_r <= wdata_r[GCTRL_GIE_BIT];
        end
    end

    // ------------------------------------------------------------
    // per-port registers, synchroniser, flags, pads
    // ------------------------------------------------------------
    genvar gp;
    genvar gb;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            // input register itself has no storage, so writes vanish
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    out_r[gp] <= RST_OUTPUT_VALUES;
                    dir_r[gp] <= RST_DIRECTION;
                    ren_r[gp] <= RST_PULL_ENABLE;
                    sel_r[gp] <= RST_FSEL_LOW;
                    sel2_r[gp] <= RST_FSEL_HIGH;
                    ies_r[gp] <= RST_EDGE_SELECT;
                    ie_r[gp] <= RST_IRQ_ENABLE;
                    osc_r[gp] <= RST_OSC_ENABLE;
                end else if (wr_port[gp]) begin
                    case (wr_off)
                        OFF_OUTPUT_VALUES: out_r[gp] <= wdata_r[7:0];
                        OFF_DIRECTION: dir_r[gp] <= wdata_r[7:0];
                        OFF_PULL_ENABLE: ren_r[gp] <= wdata_r[7:0];
                        OFF_FSEL_LOW: sel_r[gp] <= wdata_r[7:0];
                        OFF_FSEL_HIGH: sel2_r[gp] <= wdata_r[7:0];
                        OFF_EDGE_SELECT: ies_r[gp] <= wdata_r[7:0];
                        OFF_IRQ_ENABLE: ie_r[gp] <= wdata_r[7:0];
                        OFF_OSC_ENABLE: osc_r[gp] <= wdata_r[7:0];
                        default: ;
                    endcase
                end
            end

            assign flag_wr[gp] = wr_port[gp] && (wr_off == OFF_IRQ_FLAGS);

            pin_sync u_sync (
                .aclk(aclk),
                .aresetn(aresetn),
                .async_in(pin_level[gp]),
                .sync_out(level_sync[gp])
            );

            edge_irq_flags u_flags (
                .aclk(aclk),
                .aresetn(aresetn),
                .level(level_sync[gp]),
                .edge_sel(ies_r[gp]),
                .fsel_low(sel_r[gp]),
                .irq_en(ie_r[gp]),
                .global_interrupt_enable(gie_r),
                .sw_wr(flag_wr[gp]),
                .sw_data(wdata_r[7:0]),
                .flags(flags[gp]),
                .irq(port_irq[gp])
            );

            for (gb = 0; gb < NPIN; gb++) begin : g_pin
                logic [1:0] fn;
                logic drv_nxt;
                logic oe_nxt;
                logic pen_nxt;
                logic pup_nxt;
                logic drv_r;
                logic oe_r;
                logic pen_r;
                logic pup_r;
                logic pin_in_r;

                assign fn = {sel2_r[gp][gb], sel_r[gp][gb]};

                always_comb begin
                    case (fn)
                        FN_PRIMARY: drv_nxt = prim_periph_data[gp][gb];
                        FN_SECONDARY: drv_nxt = sec_periph_data[gp][gb];
                        FN_IO: drv_nxt = out_r[gp][gb];
                        default: drv_nxt = out_r[gp][gb];
                    endcase
                    oe_nxt = dir_r[gp][gb] & ~ren_r[gp][gb];
                    pen_nxt = ren_r[gp][gb];
                    pup_nxt = out_r[gp][gb];
                    if (osc_r[gp][gb]) begin
                        oe_nxt = 1'b0;
                        pen_nxt = 1'b1;
                        pup_nxt = ~level_sync[gp][gb];
                    end
                end

                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        drv_r <= 1'b0;
                        oe_r <= 1'b0;
                        pen_r <= 1'b0;
                        pup_r <= 1'b0;
                    end else begin
                        drv_r <= drv_nxt;
                        oe_r <= oe_nxt;
                        pen_r <= pen_nxt;
                        pup_r <= pup_nxt;
                    end
                end

                // peripheral input is transparent while selected
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        pin_in_r <= 1'b0;
                    end else if (sel_r[gp][gb]) begin
                        pin_in_r <= level_sync[gp][gb];
                    end
                end

                assign pin_drive[gp][gb] = drv_r;
                assign pin_drive_oe[gp][gb] = oe_r;
                assign pull_en[gp][gb] = pen_r;
                assign pull_up[gp][gb] = pup_r;
                assign periph_input[gp][gb] = pin_in_r;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // pin oscillator signal to the timer
    // ------------------------------------------------------------
    logic osc_r_out;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_r_out <= 1'b0;
        end else begin
            osc_r_out <= |(osc_r & level_sync);
        end
    end

    assign osc_timer_in = osc_r_out;

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [7:0] rd_byte;
    logic rd_ok;
    logic rd_port;
    logic [5:0] rd_off;

    assign rd_port = s_axi_araddr[PORT_SEL_BIT];
    assign rd_off = s_axi_araddr[5:0];

    always_comb begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        if (s_axi_araddr[1:0] != 2'b00) begin
            rd_ok = 1'b0;
        end else if (s_axi_araddr[GLOBAL_SEL_BIT]) begin
            rd_ok = (s_axi_araddr[6:0] == OFF_GLOBAL_CTRL);
            rd_byte = {7'h00, gie_r};
        end else begin
            case (rd_off)
                OFF_INPUT_LEVELS: rd_byte = level_sync[rd_port];
                OFF_OUTPUT_VALUES: rd_byte = out_r[rd_port];
                OFF_DIRECTION: rd_byte = dir_r[rd_port];
                OFF_PULL_ENABLE: rd_byte = ren_r[rd_port];
                OFF_FSEL_LOW: rd_byte = sel_r[rd_port];
                OFF_FSEL_HIGH: rd_byte = sel2_r[rd_port];
                OFF_IRQ_FLAGS: rd_byte = flags[rd_port];
                OFF_EDGE_SELECT: rd_byte = ies_r[rd_port];
                OFF_IRQ_ENABLE: rd_byte = ie_r[rd_port];
                OFF_OSC_ENABLE: rd_byte = osc_r[rd_port];
                default: rd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule

// ==== design/edge_irq_flags.sv ====
// edge-triggered interrupt flags of one interrupt-capable port
`timescale 1ns/10ps
module edge_irq_flags
    import gpio_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [NPIN-1:0] level, // synchronised pin levels
    input wire logic [NPIN-1:0] edge_sel, // 0 rising, 1 falling
    input wire logic [NPIN-1:0] fsel_low, // function select low bits
    input wire logic [NPIN-1:0] irq_en, // per-pin enables
    input wire logic global_interrupt_enable, // global interrupt enable
    input wire logic sw_wr, // software write of the flags
    input wire logic [NPIN-1:0] sw_data, // data of that write
    output logic [NPIN-1:0] flags, // sticky flags
    output logic irq // registered port request
);

    // ------------------------------------------------------------
    // edge detection on level xor edge select
    // ------------------------------------------------------------
    logic [NPIN-1:0] eff;
    logic [NPIN-1:0] eff_prev_r;
    // held low until the synchroniser shows the true pin level after reset
    logic [SYNC_STAGES:0] arm_r;
    logic [NPIN-1:0] hw_set;
    logic [NPIN-1:0] flags_r;
    logic irq_r;

    // a select change that meets the new edge's end level also sets
    assign eff = level ^ edge_sel;
    assign hw_set = arm_r[SYNC_STAGES] ? (eff & ~eff_prev_r & ~fsel_low)
                            : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eff_prev_r <= '0;
            arm_r <= '0;
        end else begin
            eff_prev_r <= eff;
            arm_r <= {arm_r[SYNC_STAGES-1:0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // flags: software writes, hardware only sets, set wins
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= RST_IRQ_FLAGS;
        end else if (sw_wr) begin
            flags_r <= sw_data | hw_set;
        end else begin
            flags_r <= flags_r | hw_set;
        end
    end

    // ------------------------------------------------------------
    // one request per port
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= global_interrupt_enable & (|(flags_r & irq_en));
        end
    end

    assign flags = flags_r;
    assign irq = irq_r;

endmodule

// ==== design/pin_sync.sv ====
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module pin_sync
    import gpio_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [NPIN-1:0] async_in, // raw pin levels
    output logic [NPIN-1:0] sync_out // levels in the clock domain
);

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    logic [NPIN-1:0] meta_r;
    logic [NPIN-1:0] stable_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule

// ==== shared/gpio_pkg.sv ====
// constants shared by the digital i/o port design files
package gpio_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NPORT = 2;
    localparam int NPIN = 8;
    localparam int ADDR_W = 8;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // address map: byte addresses, port block selected by one bit
    // ------------------------------------------------------------
    localparam int PORT_SEL_BIT = 6;
    localparam int GLOBAL_SEL_BIT = 7;
    localparam logic [5:0] OFF_INPUT_LEVELS = 6'h00;
    localparam logic [5:0] OFF_OUTPUT_VALUES = 6'h04;
    localparam logic [5:0] OFF_DIRECTION = 6'h08;
    localparam logic [5:0] OFF_PULL_ENABLE = 6'h0C;
    localparam logic [5:0] OFF_FSEL_LOW = 6'h10;
    localparam logic [5:0] OFF_FSEL_HIGH = 6'h14;
    localparam logic [5:0] OFF_IRQ_FLAGS = 6'h18;
    localparam logic [5:0] OFF_EDGE_SELECT = 6'h1C;
    localparam logic [5:0] OFF_IRQ_ENABLE = 6'h20;
    localparam logic [5:0] OFF_OSC_ENABLE = 6'h24;
    localparam logic [6:0] OFF_GLOBAL_CTRL = 7'h00;
    localparam int GCTRL_GIE_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OUTPUT_VALUES = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_PULL_ENABLE = 8'h00;
    localparam logic [7:0] RST_FSEL_LOW = 8'h00;
    localparam logic [7:0] RST_FSEL_HIGH = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_EDGE_SELECT = 8'h00;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_OSC_ENABLE = 8'h00;
    localparam logic RST_GIE = 1'b0;

    // ------------------------------------------------------------
    // pin function codes {select high, select low}
    // ------------------------------------------------------------
    localparam logic [1:0] FN_IO = 2'b00;
    localparam logic [1:0] FN_PRIMARY = 2'b01;
    localparam logic [1:0] FN_RESERVED = 2'b10;
    localparam logic [1:0] FN_SECONDARY = 2'b11;

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== testbench/board_model.sv ====
// board side of the pads: device driver, weak pulls and a board source
`timescale 1ns/10ps
module board_model
    import gpio_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic [NPORT-1:0][NPIN-1:0] drv, // pad value
    input wire logic [NPORT-1:0][NPIN-1:0] oe, // driver on
    input wire logic [NPORT-1:0][NPIN-1:0] pen, // pull on
    input wire logic [NPORT-1:0][NPIN-1:0] pup, // pull up
    input wire logic [NPORT-1:0][NPIN-1:0] ext_en, // board drives
    input wire logic [NPORT-1:0][NPIN-1:0] ext_val, // board level
    output logic [NPORT-1:0][NPIN-1:0] pad // resolved level
);
    logic [NPORT-1:0][NPIN-1:0] last = '0;
    always @(posedge aclk) last <= pad;
    // a floating pad keeps changing so it never reads as a held level
    assign pad = oe & drv | ~oe & (pen & pup | ~pen & (ext_en & ext_val
        | ~ext_en & ~last));
endmodule

// ==== testbench/digital_io_port_sva.sv ====
// bus and pad assertions for the digital i/o port
`timescale 1ns/10ps
module digital_io_port_sva
    import gpio_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [NPORT-1:0][NPIN-1:0] pin_drive_oe, // driver on
    input wire logic [NPORT-1:0][NPIN-1:0] pull_en, // pull on
    input wire logic [NPORT-1:0] port_irq // requests
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_B_LATE: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) else $error("write taken while busy");
    AST_R_LATE: assert property (rd_take |=> s_axi_rvalid
        && !s_axi_arready) else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    AST_R_UPPER: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 0) else $error("upper read bits set");
    AST_PULL_OFF: assert property ((pull_en & pin_drive_oe) == 0)
        else $error("driver on with pull");
    AST_RST: assert property ($rose(aresetn) |-> port_irq == 0)
        else $error("request after reset");
endmodule
bind digital_io_port digital_io_port_sva u_sva (.*);

// ==== testbench/digital_io_port_tb.sv ====
// self-checking bench for the digital i/o port
`timescale 1ns/10ps
module digital_io_port_tb
    import gpio_pkg::*;
;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, osc_timer_in;
    logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, port_irq;
    logic [NPORT-1:0][NPIN-1:0] pin_level, pin_drive, pin_drive_oe, pull_en;
    logic [NPORT-1:0][NPIN-1:0] pull_up, periph_input, ext_val = 0;
    logic [NPORT-1:0][NPIN-1:0] prim_periph_data = 16'h0040;
    logic [NPORT-1:0][NPIN-1:0] sec_periph_data = 16'h0041;
    logic [7:0] fexp [4] = '{8'h01, 8'h40, 8'h01, 8'h41};
    int n_fail = 0, cmp_count = 0, n;
    always #2 aclk = ~aclk;
    digital_io_port DUT (.*);
    board_model board (.aclk(aclk), .drv(pin_drive), .oe(pin_drive_oe),
        .pen(pull_en), .pup(pull_up), .ext_en(16'hff00),
        .ext_val(ext_val), .pad(pin_level));
    task automatic chk(input string s, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d, input logic [1:0] er = 0);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1;
        @(posedge aclk);
        s_axi_bready <= 0;
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, e, input logic [1:0] er = 0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1;
        @(posedge aclk);
        s_axi_rready <= 0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        for (int o = 4; o <= 36; o += 4) rd({2'b01, 6'(o)}, 8'h00);
        wr({2'b00, OFF_DIRECTION}, 8'hff);
        repeat (4) @(posedge aclk);
        wr({2'b00, OFF_IRQ_FLAGS}, 8'h00);
        wr({2'b00, OFF_OUTPUT_VALUES}, 8'ha5);
        chk("drive", 8'ha5, pin_drive[0]);
        repeat (4) @(posedge aclk);
        wr({2'b00, OFF_INPUT_LEVELS}, 8'h00);
        rd({2'b00, OFF_INPUT_LEVELS}, 8'ha5);
        rd({2'b00, OFF_IRQ_FLAGS}, 8'ha5);
        wr({2'b00, OFF_PULL_ENABLE}, 8'h0f);
        chk("pull_up", 8'h05, pull_up[0] & pull_en[0]);
        chk("oe", 8'hf0, pin_drive_oe[0]);
        wr({2'b00, OFF_PULL_ENABLE}, 8'h00);
        for (int f = 0; f < 4; f++) begin
            wr({2'b00, OFF_FSEL_HIGH}, f[1] ? 8'h41 : 8'h00);
            wr({2'b00, OFF_FSEL_LOW}, f[0] ? 8'h41 : 8'h00);
            chk("fsel", fexp[f], pin_drive[0] & 8'h41);
        end
        chk("dir_kept", 8'hff, pin_drive_oe[0]);
        wr({2'b01, OFF_IRQ_ENABLE}, 8'h01);
        ext_val[1] <= 8'h03;
        repeat (5) @(posedge aclk);
        rd({2'b01, OFF_IRQ_FLAGS}, 8'h03);
        chk("irq_nogie", 2'b00, port_irq);
        wr(8'h80, 8'h01);
        @(posedge aclk);
        chk("irq", 2'b10, port_irq);
        wr({2'b01, OFF_IRQ_FLAGS}, 8'h80);
        @(posedge aclk);
        chk("irq_mask", 2'b00, port_irq);
        rd({2'b01, OFF_IRQ_FLAGS}, 8'h80);
        wr({2'b01, OFF_IRQ_FLAGS}, 8'h00);
        ext_val[1] <= 8'h02;
        repeat (5) @(posedge aclk);
        rd({2'b01, OFF_IRQ_FLAGS}, 8'h00);
        wr({2'b01, OFF_EDGE_SELECT}, 8'h01);
        rd({2'b01, OFF_IRQ_FLAGS}, 8'h01);
        wr({2'b01, OFF_FSEL_LOW}, 8'h04);
        wr({2'b01, OFF_IRQ_FLAGS}, 8'h00);
        ext_val[1] <= 8'h06;
        repeat (5) @(posedge aclk);
        chk("periph", 8'h04, periph_input[1] & 8'h04);
        rd({2'b01, OFF_IRQ_FLAGS}, 8'h00);
        wr({2'b01, OFF_FSEL_LOW}, 8'h00);
        ext_val[1] <= 8'h02;
        repeat (5) @(posedge aclk);
        chk("periph_hold", 8'h04, periph_input[1] & 8'h04);
        wr({2'b01, OFF_OSC_ENABLE}, 8'h80);
        n = 0;
        repeat (16) begin
            @(posedge aclk);
            n += (osc_timer_in === 1'b1);
        end
        chk("osc_runs", 1, n > 0 && n < 16);
        chk("osc_pad", 8'h80, pull_en[1] & ~pin_drive_oe[1] & 8'h80);
        rd(8'h80, 8'h01);
        s_axi_wstrb <= 4'h0;
        wr({2'b01, OFF_IRQ_ENABLE}, 8'hff);
        s_axi_wstrb <= 4'hf;
        rd({2'b01, OFF_IRQ_ENABLE}, 8'h01);
        rd(8'h7c, 8'h00, RESP_SLVERR);
        wr(8'h84, 8'h01, RESP_SLVERR);
        end_of_test();
    end
    initial begin
        #40000;
        n_fail++;
        end_of_test();
    end
endmodule
